// File: core/dmx_exec.sv
// Decode and execute unit for the data-move instruction group.
// Assumes one instruction offered at a time on instr_valid and that
// other core logic writes data memory only through the ext port.
//
// How it works
// RL1: Address nibble loads timer one reload high
// RL2: Address nibble loads table pointer low
// RL3: Address nibble loads table pointer high
// RL4: Display RAM nibble loads working register
// RL5: Address nibble loads working register
// RL6: Paged indirect load into working register
// RL7: Paged indirect store from working register
// RL8: Address nibble loads page register
// RL9: Carry to bit zero, acc and memory
// RL10: Low wake flags to acc and memory
// RL11: Divider overflow wake sets flag bit zero
// RL12: Timer zero wake sets flag bit one
// RL13: Port change wake sets flag bit two
// RL14: High wake flags to acc and memory
// RL15: Timer one wake sets high bit one
// RL16: Reserved flags zero, 128-nibble address space
`timescale 1ns/1ns
`include "dmx_params.svh"
module dmx_exec (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [`DMX_INSTR_W-1:0] instr_word,
  output logic instr_ready,
  output logic instr_done,
  input wire logic carry_flag,
  input wire logic ext_wr_en,
  input wire logic [`DMX_MEM_AW-1:0] ext_wr_addr,
  input wire logic [`DMX_NIB_W-1:0] ext_wr_data,
  input wire logic disp_wr_en,
  input wire logic [`DMX_DISP_AW-1:0] disp_wr_addr,
  input wire logic [`DMX_NIB_W-1:0] disp_wr_data,
  input wire logic hold_mode,
  input wire logic div0_overflow,
  input wire logic timer0_underflow,
  input wire logic timer1_underflow,
  input wire logic [3:0] external_interrupt_port,
  output dmx_pkg::dmx_op_type active_op,
  output logic [`DMX_NIB_W-1:0] accumulator,
  output logic zero_flag,
  output logic [`DMX_NIB_W-1:0] timer_one_reload_high,
  output logic timer_one_reload_high_load,
  output logic [`DMX_NIB_W-1:0] table_pointer_low,
  output logic [`DMX_NIB_W-1:0] table_pointer_high,
  output logic [`DMX_NIB_W-1:0] page_register,
  output logic [`DMX_WAKE_W-1:0] wake_cause_flags,
  output logic hold_exit
);
  import dmx_pkg::*;

  dmx_state_type state_r;
  dmx_state_type state_nxt;
  dmx_op_type op_r;
  dmx_op_type dec_op;
  logic [`DMX_WREG_W-1:0] wreg_r;
  logic [`DMX_MEM_AW-1:0] addr_r;
  logic [`DMX_MEM_AW-1:0] ptr_r;
  logic accept;
  logic last_cycle;
  logic mem_rd_en;
  logic [`DMX_MEM_AW-1:0] mem_rd_addr;
  logic [`DMX_NIB_W-1:0] mem_rd_data;
  logic core_wr_en;
  logic [`DMX_MEM_AW-1:0] core_wr_addr;
  logic [`DMX_NIB_W-1:0] core_wr_data;
  logic mem_wr_en;
  logic [`DMX_MEM_AW-1:0] mem_wr_addr;
  logic [`DMX_NIB_W-1:0] mem_wr_data;
  logic disp_rd_en;
  logic [`DMX_DISP_AW-1:0] disp_rd_addr;
  logic [`DMX_NIB_W-1:0] disp_rd_data;
  logic acc_wr_en;
  logic [`DMX_NIB_W-1:0] acc_wr_data;
  logic [`DMX_NIB_W-1:0] wake_lo;
  logic [`DMX_NIB_W-1:0] wake_hi;
  logic [`DMX_MEM_AW-1:0] wreg_addr;
  logic [`DMX_MEM_AW-1:0] ind_addr;

  function automatic dmx_op_type decode(input logic [`DMX_INSTR_W-1:0] w);
    dmx_op_type op;
    op = DMX_OP_NONE;
    if (w[15:7] == `DMX_OPC_TMR1_HI) begin
      op = DMX_OP_TMR1_HI;
    end else if (w[15:7] == `DMX_OPC_TAB_LO) begin
      op = DMX_OP_TAB_LO;
    end else if (w[15:7] == `DMX_OPC_TAB_HI) begin
      op = DMX_OP_TAB_HI;
    end else if (w[15:9] == `DMX_OPC_DISP_RD) begin
      op = DMX_OP_DISP_RD;
    end else if (w[15:11] == `DMX_OPC_MOV_WR) begin
      op = DMX_OP_MOV_WR;
    end else if (w[15:11] == `DMX_OPC_IND_LD) begin
      op = DMX_OP_IND_LD;
    end else if (w[15:11] == `DMX_OPC_IND_ST) begin
      op = DMX_OP_IND_ST;
    end else if (w[15:8] == `DMX_OPC_PAGE_LD) begin
      op = DMX_OP_PAGE_LD;
    end else if (w[15:7] == `DMX_OPC_CARRY) begin
      op = DMX_OP_CARRY;
    end else if (w[15:7] == `DMX_OPC_WAKE_LO) begin
      op = DMX_OP_WAKE_LO;
    end else if (w[15:7] == `DMX_OPC_WAKE_HI) begin
      op = DMX_OP_WAKE_HI;
    end
    return op;
  endfunction

  assign dec_op = decode(instr_word);
  assign instr_ready = (state_r == DMX_ST_IDLE);
  assign accept = instr_valid && instr_ready;
  assign active_op = op_r;
  assign wake_lo = wake_cause_flags[3:0];
  assign wake_hi = wake_cause_flags[7:4];
  assign wreg_addr = {3'h0, wreg_r};
  // RL6: page bits times 10H plus pointer
  assign ind_addr = {page_register[`DMX_PAGE_SEL_W-1:0], mem_rd_data};

  // Sequencer: one machine cycle is two clocks, indirect takes four
  always_comb begin
    state_nxt = state_r;
    last_cycle = 1'b0;
    case (state_r)
      DMX_ST_IDLE: begin
        if (accept) begin
          state_nxt = DMX_ST_EXEC;
        end
      end
      DMX_ST_EXEC: begin
        if (op_r == DMX_OP_IND_LD || op_r == DMX_OP_IND_ST) begin
          state_nxt = DMX_ST_IND_A;
        end else begin
          state_nxt = DMX_ST_IDLE;
          last_cycle = 1'b1;
        end
      end
      DMX_ST_IND_A: begin
        state_nxt = DMX_ST_IND_B;
      end
      DMX_ST_IND_B: begin
        state_nxt = DMX_ST_IDLE;
        last_cycle = 1'b1;
      end
      default: begin
        state_nxt = DMX_ST_IDLE;
      end
    endcase
  end

  assign instr_done = last_cycle;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= DMX_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latch the instruction fields at acceptance
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_r <= DMX_OP_NONE;
      wreg_r <= 4'h0;
      addr_r <= 7'h00;
    end else if (accept) begin
      op_r <= dec_op;
      addr_r <= instr_word[`DMX_F_ADDR_LSB +: `DMX_MEM_AW];
      if (dec_op == DMX_OP_DISP_RD) begin
        wreg_r <= instr_word[`DMX_F_DWREG_LSB +: `DMX_WREG_W];
      end else begin
        wreg_r <= instr_word[`DMX_F_WREG_LSB +: `DMX_WREG_W];
      end
    end else if (last_cycle) begin
      op_r <= DMX_OP_NONE;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= 7'h00;
    end else if (state_r == DMX_ST_EXEC) begin
      ptr_r <= ind_addr;
    end
  end

  // Read port steering
  always_comb begin
    mem_rd_en = 1'b0;
    mem_rd_addr = instr_word[`DMX_F_ADDR_LSB +: `DMX_MEM_AW];
    disp_rd_en = 1'b0;
    disp_rd_addr = instr_word[`DMX_F_DADDR_LSB +: `DMX_DISP_AW];
    case (state_r)
      DMX_ST_IDLE: begin
        // RL16: 7-bit field selects one of 128
        mem_rd_en = accept && (dec_op != DMX_OP_NONE) && (dec_op != DMX_OP_DISP_RD);
        disp_rd_en = accept && (dec_op == DMX_OP_DISP_RD);
      end
      DMX_ST_EXEC: begin
        if (op_r == DMX_OP_IND_LD) begin
          mem_rd_en = 1'b1;
          mem_rd_addr = ind_addr;
        end else if (op_r == DMX_OP_IND_ST) begin
          mem_rd_en = 1'b1;
          mem_rd_addr = wreg_addr;
        end
      end
      default: begin
        mem_rd_en = 1'b0;
      end
    endcase
  end

  // Core write-back into data memory and accumulator source
  always_comb begin
    core_wr_en = 1'b0;
    core_wr_addr = addr_r;
    core_wr_data = mem_rd_data;
    acc_wr_en = 1'b0;
    acc_wr_data = mem_rd_data;
    if (state_r == DMX_ST_EXEC) begin
      case (op_r)
        DMX_OP_DISP_RD: begin
          // RL4: display nibble into working register
          core_wr_en = 1'b1;
          core_wr_addr = wreg_addr;
          core_wr_data = disp_rd_data;
        end
        DMX_OP_MOV_WR: begin
          // RL5: memory nibble into working register
          core_wr_en = 1'b1;
          core_wr_addr = wreg_addr;
        end
        DMX_OP_CARRY: begin
          // RL9: carry into bit zero only
          core_wr_en = 1'b1;
          core_wr_data = {3'h0, carry_flag};
          acc_wr_en = 1'b1;
          acc_wr_data = {3'h0, carry_flag};
        end
        DMX_OP_WAKE_LO: begin
          // RL10: low flags to both
          core_wr_en = 1'b1;
          core_wr_data = wake_lo;
          acc_wr_en = 1'b1;
          acc_wr_data = wake_lo;
        end
        DMX_OP_WAKE_HI: begin
          // RL14: high flags to both
          core_wr_en = 1'b1;
          core_wr_data = wake_hi;
          acc_wr_en = 1'b1;
          acc_wr_data = wake_hi;
        end
        default: begin
          core_wr_en = 1'b0;
        end
      endcase
    end else if (state_r == DMX_ST_IND_A) begin
      if (op_r == DMX_OP_IND_LD) begin
        // RL6: indirect nibble into working register
        core_wr_en = 1'b1;
        core_wr_addr = wreg_addr;
      end else if (op_r == DMX_OP_IND_ST) begin
        // RL7: working register to paged address
        core_wr_en = 1'b1;
        core_wr_addr = ptr_r;
      end
    end
  end

  // Core write has priority over the external port
  assign mem_wr_en = core_wr_en || ext_wr_en;
  assign mem_wr_addr = core_wr_en ? core_wr_addr : ext_wr_addr;
  assign mem_wr_data = core_wr_en ? core_wr_data : ext_wr_data;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      accumulator <= `DMX_NIB_RST;
      zero_flag <= 1'b0;
    end else if (acc_wr_en) begin
      accumulator <= acc_wr_data;
      zero_flag <= (acc_wr_data == 4'h0);
    end
  end

  // RL1: timer one reload high nibble
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_one_reload_high <= `DMX_NIB_RST;
      timer_one_reload_high_load <= 1'b0;
    end else begin
      timer_one_reload_high_load <= 1'b0;
      if (state_r == DMX_ST_EXEC && op_r == DMX_OP_TMR1_HI) begin
        timer_one_reload_high <= mem_rd_data;
        timer_one_reload_high_load <= 1'b1;
      end
    end
  end

  // RL2: table pointer low nibble
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_pointer_low <= `DMX_NIB_RST;
    end else if (state_r == DMX_ST_EXEC && op_r == DMX_OP_TAB_LO) begin
      table_pointer_low <= mem_rd_data;
    end
  end

  // RL3: table pointer high nibble
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_pointer_high <= `DMX_NIB_RST;
    end else if (state_r == DMX_ST_EXEC && op_r == DMX_OP_TAB_HI) begin
      table_pointer_high <= mem_rd_data;
    end
  end

  // RL8: page register load
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_register <= `DMX_NIB_RST;
    end else if (state_r == DMX_ST_EXEC && op_r == DMX_OP_PAGE_LD) begin
      page_register <= mem_rd_data;
    end
  end

  dmx_nibble_mem #(
    .DEPTH(`DMX_MEM_DEPTH),
    .AW(`DMX_MEM_AW),
    .DW(`DMX_NIB_W)
  ) u_data_mem (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  dmx_nibble_mem #(
    .DEPTH(`DMX_DISP_DEPTH),
    .AW(`DMX_DISP_AW),
    .DW(`DMX_NIB_W)
  ) u_disp_mem (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_en(disp_wr_en),
    .wr_addr(disp_wr_addr),
    .wr_data(disp_wr_data),
    .rd_en(disp_rd_en),
    .rd_addr(disp_rd_addr),
    .rd_data(disp_rd_data)
  );

  dmx_wake_flags u_wake (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .hold_mode(hold_mode),
    .div0_overflow(div0_overflow),
    .timer0_underflow(timer0_underflow),
    .timer1_underflow(timer1_underflow),
    .external_interrupt_port(external_interrupt_port),
    .wake_cause_flags(wake_cause_flags),
    .hold_exit(hold_exit)
  );
endmodule // dmx_exec

// File: core/dmx_nibble_mem.sv
// Small nibble memory, one write and one registered read per clock.
// Assumes a single clock; array contents are not reset.
`timescale 1ns/1ns
module dmx_nibble_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter int DW = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Read before write on a same-address collision
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule // dmx_nibble_mem

// File: core/dmx_params.svh
// Constants for the data-move execution unit.
// Assumes 16-bit instruction words and 4-bit data nibbles.
`ifndef DMX_PARAMS_SVH
`define DMX_PARAMS_SVH

`define DMX_NIB_W 4
`define DMX_INSTR_W 16
`define DMX_MEM_AW 7
`define DMX_MEM_DEPTH 128
`define DMX_DISP_AW 5
`define DMX_DISP_DEPTH 32
`define DMX_WREG_W 4
`define DMX_WAKE_W 8
`define DMX_PAGE_SEL_W 3

// Opcode prefixes, compared against the top bits of the word
`define DMX_OPC_TMR1_HI 9'h02B
`define DMX_OPC_TAB_LO 9'h130
`define DMX_OPC_TAB_HI 9'h131
`define DMX_OPC_DISP_RD 7'h26
`define DMX_OPC_MOV_WR 5'h1D
`define DMX_OPC_IND_LD 5'h19
`define DMX_OPC_IND_ST 5'h1B
`define DMX_OPC_PAGE_LD 8'h5D
`define DMX_OPC_CARRY 9'h0B2
`define DMX_OPC_WAKE_LO 9'h092
`define DMX_OPC_WAKE_HI 9'h093

// Field positions inside the instruction word
`define DMX_F_ADDR_LSB 0
`define DMX_F_WREG_LSB 7
`define DMX_F_DWREG_LSB 0
`define DMX_F_DADDR_LSB 4

// Reset values
`define DMX_NIB_RST 4'h0
`define DMX_WAKE_RST 8'h00

// Wake-cause bit positions
`define DMX_WAKE_DIV0 0
`define DMX_WAKE_TMR0 1
`define DMX_WAKE_EXT 2
`define DMX_WAKE_TMR1 5

// Clocks per machine cycle
`define DMX_CLK_PER_MC 2

`endif

// File: core/dmx_pkg.sv
// Types shared by the data-move execution unit.
// Assumes dmx_params.svh is available on the include path.
package dmx_pkg;

  typedef enum logic [3:0] {
    DMX_OP_NONE,
    DMX_OP_TMR1_HI,
    DMX_OP_TAB_LO,
    DMX_OP_TAB_HI,
    DMX_OP_DISP_RD,
    DMX_OP_MOV_WR,
    DMX_OP_IND_LD,
    DMX_OP_IND_ST,
    DMX_OP_PAGE_LD,
    DMX_OP_CARRY,
    DMX_OP_WAKE_LO,
    DMX_OP_WAKE_HI
  } dmx_op_type;

  typedef enum logic [2:0] {
    DMX_ST_IDLE,
    DMX_ST_EXEC,
    DMX_ST_IND_A,
    DMX_ST_IND_B
  } dmx_state_type;

endpackage

// File: core/dmx_wake_flags.sv
// Wake-cause flags captured while the core sits in HOLD.
// Assumes timer and divider events are one-cycle pulses on sys_clk;
// the external port arrives from pins and is synchronised here.
`timescale 1ns/1ns
`include "dmx_params.svh"
module dmx_wake_flags (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic hold_mode,
  input wire logic div0_overflow,
  input wire logic timer0_underflow,
  input wire logic timer1_underflow,
  input wire logic [3:0] external_interrupt_port,
  output logic [`DMX_WAKE_W-1:0] wake_cause_flags,
  output logic hold_exit
);
  logic [3:0] ext_meta_r;
  logic [3:0] ext_sync_r;
  logic [3:0] ext_prev_r;
  logic hold_d_r;
  logic ext_change;
  logic hold_entry;
  logic [`DMX_WAKE_W-1:0] wake_event;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_meta_r <= 4'h0;
      ext_sync_r <= 4'h0;
      ext_prev_r <= 4'h0;
    end else begin
      ext_meta_r <= external_interrupt_port;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_d_r <= 1'b0;
    end else begin
      hold_d_r <= hold_mode;
    end
  end

  assign ext_change = |(ext_sync_r ^ ext_prev_r);
  assign hold_entry = hold_mode && !hold_d_r;

  always_comb begin
    wake_event = `DMX_WAKE_RST;
    // RL11: divider overflow wake
    wake_event[`DMX_WAKE_DIV0] = hold_mode && div0_overflow;
    // RL12: timer zero wake
    wake_event[`DMX_WAKE_TMR0] = hold_mode && timer0_underflow;
    // RL13: port change wake
    wake_event[`DMX_WAKE_EXT] = hold_mode && ext_change;
    // RL15: timer one wake
    wake_event[`DMX_WAKE_TMR1] = hold_mode && timer1_underflow;
  end

  // RL16: reserved bits stay zero
  genvar gi;
  generate
    for (gi = 0; gi < `DMX_WAKE_W; gi++) begin : g_flag
      // Set wins over the clear at HOLD entry
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          wake_cause_flags[gi] <= 1'b0;
        end else if (wake_event[gi]) begin
          wake_cause_flags[gi] <= 1'b1;
        end else if (hold_entry) begin
          wake_cause_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_exit <= 1'b0;
    end else begin
      hold_exit <= |wake_event;
    end
  end
endmodule // dmx_wake_flags

// File: testbench/dmx_exec_props.sv
// Timing and result checks for the data-move execution unit.
// Assumes the dmx_exec port list and dmx_params.svh on the include path.
`timescale 1ns/1ns
`include "dmx_params.svh"
module dmx_exec_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [`DMX_INSTR_W-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic carry_flag,
  input wire logic hold_mode,
  input wire logic div0_overflow,
  input wire logic timer0_underflow,
  input wire logic timer1_underflow,
  input wire dmx_pkg::dmx_op_type active_op,
  input wire logic [`DMX_NIB_W-1:0] accumulator,
  input wire logic zero_flag,
  input wire logic timer_one_reload_high_load,
  input wire logic [`DMX_NIB_W-1:0] table_pointer_low,
  input wire logic [`DMX_WAKE_W-1:0] wake_cause_flags,
  input wire logic hold_exit
);
  import dmx_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  AST_ONE_CYCLE: assert property (
    (instr_valid && instr_ready && instr_word[15:11] != 5'h19 && instr_word[15:11] != 5'h1B) |=> instr_done)
    else $error("done not one cycle after accept");
  AST_IND_LOAD: assert property (
    (instr_valid && instr_ready && instr_word[15:11] == 5'h19) |=> !instr_done [*2] ##1 instr_done)
    else $error("indirect load timing wrong");
  AST_IND_STORE: assert property (
    (instr_valid && instr_ready && instr_word[15:11] == 5'h1B) |=> !instr_done [*2] ##1 instr_done)
    else $error("indirect store timing wrong");
  AST_TMR1_LOAD: assert property (
    (instr_done && active_op == DMX_OP_TMR1_HI) |=> timer_one_reload_high_load)
    else $error("reload high load pulse missing");
  AST_TAB_LOW: assert property (
    !$stable(table_pointer_low) |-> $past(instr_done) && $past(active_op) == DMX_OP_TAB_LO)
    else $error("table pointer low changed without its op");
  AST_CARRY: assert property (
    (instr_done && active_op == DMX_OP_CARRY) |=>
      accumulator == {3'b000, $past(carry_flag)} && zero_flag == !$past(carry_flag))
    else $error("carry copy result wrong");
  AST_WAKE_LOW: assert property (
    (instr_done && active_op == DMX_OP_WAKE_LO) |=>
      accumulator == $past(wake_cause_flags[3:0]) && zero_flag == (accumulator == 4'h0))
    else $error("low wake read wrong");
  AST_WAKE_HIGH: assert property (
    (instr_done && active_op == DMX_OP_WAKE_HI) |=>
      accumulator == $past(wake_cause_flags[7:4]) && zero_flag == (accumulator == 4'h0))
    else $error("high wake read wrong");
  AST_RESERVED: assert property (
    wake_cause_flags[7:6] == 2'b00 && wake_cause_flags[4:3] == 2'b00)
    else $error("reserved wake bit set");
  AST_DIV0_WAKE: assert property (
    (hold_mode && div0_overflow) |=> wake_cause_flags[0] && hold_exit)
    else $error("divider wake not flagged");
  AST_TMR0_WAKE: assert property (
    (hold_mode && timer0_underflow) |=> wake_cause_flags[1])
    else $error("timer zero wake not flagged");
  AST_TMR1_WAKE: assert property (
    (hold_mode && timer1_underflow) |=> wake_cause_flags[5])
    else $error("timer one wake not flagged");
endmodule // dmx_exec_props

bind dmx_exec dmx_exec_props u_props (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .instr_ready(instr_ready),
  .instr_done(instr_done),
  .carry_flag(carry_flag),
  .hold_mode(hold_mode),
  .div0_overflow(div0_overflow),
  .timer0_underflow(timer0_underflow),
  .timer1_underflow(timer1_underflow),
  .active_op(active_op),
  .accumulator(accumulator),
  .zero_flag(zero_flag),
  .timer_one_reload_high_load(timer_one_reload_high_load),
  .table_pointer_low(table_pointer_low),
  .wake_cause_flags(wake_cause_flags),
  .hold_exit(hold_exit)
);

// File: testbench/test_data_move_instruction_exec.sv
// Self-checking bench for the data-move execution unit.
// Assumes memory preload through the ext write port; drives at falling edges.
`timescale 1ns/1ns
`include "dmx_params.svh"
module test_data_move_instruction_exec;
  import dmx_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic carry_flag = 1'b0;
  logic ext_wr_en = 1'b0;
  logic [6:0] ext_wr_addr = 7'h00;
  logic [3:0] ext_wr_data = 4'h0;
  logic disp_wr_en = 1'b0;
  logic [4:0] disp_wr_addr = 5'h00;
  logic [3:0] disp_wr_data = 4'h0;
  logic hold_mode = 1'b0;
  logic [2:0] wake_ev = 3'h0;
  logic [3:0] external_interrupt_port = 4'h0;
  logic instr_ready, instr_done, zero_flag, reload_load, hold_exit;
  dmx_op_type active_op;
  logic [3:0] accumulator, reload_high, tab_lo, tab_hi, page_register;
  logic [7:0] wake_cause_flags;
  int errors = 0;
  int total_checks = 0;
  always #2 sys_clk = ~sys_clk;
  dmx_exec uut (.sys_clk(sys_clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .instr_done(instr_done), .carry_flag(carry_flag), .ext_wr_en(ext_wr_en),
    .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data), .disp_wr_en(disp_wr_en),
    .disp_wr_addr(disp_wr_addr), .disp_wr_data(disp_wr_data), .hold_mode(hold_mode),
    .div0_overflow(wake_ev[0]), .timer0_underflow(wake_ev[1]), .timer1_underflow(wake_ev[2]),
    .external_interrupt_port(external_interrupt_port), .active_op(active_op), .accumulator(accumulator),
    .zero_flag(zero_flag), .timer_one_reload_high(reload_high), .timer_one_reload_high_load(reload_load),
    .table_pointer_low(tab_lo), .table_pointer_high(tab_hi), .page_register(page_register),
    .wake_cause_flags(wake_cause_flags), .hold_exit(hold_exit));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic poke(input logic [6:0] a, input logic [3:0] d);
    @(negedge sys_clk);
    ext_wr_en = 1'b1;
    ext_wr_addr = a;
    ext_wr_data = d;
    @(negedge sys_clk);
    ext_wr_en = 1'b0;
  endtask
  // Offer one word, wait for done, let results land
  task automatic run(input logic [15:0] w);
    int n;
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    n = 0;
    while (instr_done !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk("instr_done", 8'h01, {7'h00, instr_done});
    chk("instr_ready", 8'h00, {7'h00, instr_ready});
    @(negedge sys_clk);
    chk("instr_ready", 8'h01, {7'h00, instr_ready});
  endtask
  // Memory readback via the table pointer low load
  task automatic rdm(input logic [6:0] a, input logic [3:0] e);
    run({`DMX_OPC_TAB_LO, a});
    chk("mem", {4'h0, e}, {4'h0, tab_lo});
  endtask
  task automatic acc_chk(input logic [3:0] a, input logic z);
    chk("accumulator", {4'h0, a}, {4'h0, accumulator});
    chk("zero_flag", {7'h00, z}, {7'h00, zero_flag});
  endtask
  task automatic wake(input logic [2:0] ev, input logic [7:0] e);
    @(negedge sys_clk);
    wake_ev = ev;
    @(negedge sys_clk);
    wake_ev = 3'h0;
    chk("wake_flags", e, wake_cause_flags);
    chk("hold_exit", 8'h01, {7'h00, hold_exit});
  endtask
  initial begin
    repeat (4000) @(posedge sys_clk);
    errors++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    chk("wake_flags", 8'h00, wake_cause_flags);
    poke(7'h7F, 4'h5);
    poke(7'h40, 4'hA);
    poke(7'h41, 4'h3);
    poke(7'h42, 4'hB);
    poke(7'h43, 4'h6);
    poke(7'h36, 4'hC);
    poke(7'h44, 4'h2);
    @(negedge sys_clk);
    disp_wr_en = 1'b1;
    disp_wr_addr = 5'h1F;
    disp_wr_data = 4'h9;
    @(negedge sys_clk);
    disp_wr_en = 1'b0;
    run({`DMX_OPC_TMR1_HI, 7'h7F});
    chk("reload_high", 8'h05, {4'h0, reload_high});
    run({`DMX_OPC_TAB_LO, 7'h40});
    chk("tab_lo", 8'h0A, {4'h0, tab_lo});
    run({`DMX_OPC_TAB_HI, 7'h41});
    chk("tab_hi", 8'h03, {4'h0, tab_hi});
    run({`DMX_OPC_PAGE_LD, 1'b0, 7'h42});
    chk("page", 8'h0B, {4'h0, page_register});
    run({`DMX_OPC_DISP_RD, 5'h1F, 4'h3});
    rdm(7'h03, 4'h9);
    run({`DMX_OPC_MOV_WR, 4'h5, 7'h7F});
    rdm(7'h05, 4'h5);
    run({`DMX_OPC_IND_LD, 4'h7, 7'h43});
    rdm(7'h07, 4'hC);
    run({`DMX_OPC_IND_ST, 4'h7, 7'h44});
    rdm(7'h32, 4'hC);
    carry_flag = 1'b1;
    run({`DMX_OPC_CARRY, 7'h50});
    acc_chk(4'h1, 1'b0);
    rdm(7'h50, 4'h1);
    carry_flag = 1'b0;
    run({`DMX_OPC_CARRY, 7'h51});
    acc_chk(4'h0, 1'b1);
    hold_mode = 1'b1;
    repeat (2) @(negedge sys_clk);
    wake(3'h1, 8'h01);
    wake(3'h2, 8'h03);
    wake(3'h4, 8'h23);
    external_interrupt_port = 4'h1;
    repeat (6) @(negedge sys_clk);
    chk("wake_flags", 8'h27, wake_cause_flags);
    chk("hold_exit", 8'h00, {7'h00, hold_exit});
    run({`DMX_OPC_WAKE_LO, 7'h52});
    acc_chk(4'h7, 1'b0);
    rdm(7'h52, 4'h7);
    run({`DMX_OPC_WAKE_HI, 7'h53});
    acc_chk(4'h2, 1'b0);
    rdm(7'h53, 4'h2);
    hold_mode = 1'b0;
    @(negedge sys_clk);
    hold_mode = 1'b1;
    repeat (2) @(negedge sys_clk);
    run({`DMX_OPC_WAKE_LO, 7'h54});
    acc_chk(4'h0, 1'b1);
    close_out();
  end
endmodule // test_data_move_instruction_exec
